// File: dv/mbsp_partner.sv
`timescale 1ns/1ps
// ****************************************
// Serial peripheral on the far side
// ****************************************
module mbsp_partner (
  input wire logic sys_clk, sclk, sel_n, mosi, pol,
  input wire logic [15:0] tx_word,
  input wire logic [3:0] tx_m1,
  output logic miso,
  output logic [15:0] got,
  output int per, lead, lag, rises
);
  logic sclk_q = 1'b0;
  logic sel_q = 1'b1;
  logic fst = 1'b1;
  logic tgl = 1'b0;
  logic [3:0] bi = 4'h0;
  int cnt = 0;
  int since = 0;
  int tc = 0;
  initial {got, per, lead, lag, rises} = '0;
  // Released line toggles, so a stale bit is never read
  assign miso = sel_n ? tgl : tx_word[bi];
  // follow the clock, take data on the leading edge
  always @(posedge sys_clk) begin
    tgl <= ~tgl;
    cnt <= cnt + 1;
    since <= since + 1;
    tc <= tc + 1;
    if (sel_n) begin
      bi <= tx_m1;
      fst <= 1'b1;
      cnt <= 0;
      if (!sel_q) begin
        lag <= tc;
        rises <= rises + 1;
      end
    // Idle clock level may flip with select on a new polarity
    end else if (!sel_q && sclk != sclk_q) begin
      tc <= 1;
      fst <= 1'b0;
      if (fst) lead <= cnt;
      if (sclk != pol) begin
        got <= {got[14:0], mosi};
        per <= since;
        since <= 1;
      end else bi <= bi - 4'h1;
    end
    if (!sel_n && sel_q) got <= 16'h0000;
    sclk_q <= sclk;
    sel_q <= sel_n;
  end
endmodule

// File: dv/mbsp_top_sva.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module mbsp_top_sva (
  input wire logic sys_clk, rst, controller_mode,
  input wire mbsp_pkg::mbsp_fmt_s word_format_register_0,
  input wire logic grp_start, grp_busy, grp_done,
  input wire logic rx_valid, rx_ready,
  input wire logic [15:0] rx_data,
  input wire logic [3:0] gpio_sel, gpio_dir, gpio_out, gpio_in,
  input wire logic [3:0] pin_i, pin_o, pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Select held low by the serial engine
  wire spi_on = controller_mode && gpio_sel == 4'h0 && pin_oe[3] && !pin_o[3];
  sequence s_edge;
    spi_on && $changed(pin_o[0]);
  endsequence
  sequence s_lead;
    s_edge ##0 pin_o[0] != word_format_register_0.polarity;
  endsequence
  sequence s_peri;
    !controller_mode && !gpio_sel[0];
  endsequence
  // Reset must not be masked here
  property p_rst_quiet;
    disable iff (1'b0) rst |=> pin_oe == 4'h0 && !grp_busy && !grp_done;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
  property p_start;
    grp_start && !grp_busy |=> grp_busy;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_done;
    grp_done |=> !grp_done && !grp_busy;
  endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_half;
    s_edge |=> $stable(pin_o[0]);
  endproperty
  a_half: assert property (p_half) else $error("clock half too short");
  property p_data;
    s_lead |-> $stable(pin_o[1]);
  endproperty
  a_data: assert property (p_data) else $error("data moved on lead");
  property p_peri;
    s_peri ##1 s_peri |-> !pin_oe[0];
  endproperty
  a_peri: assert property (p_peri) else $error("clock driven");
  // Plain outputs follow one cycle later
  property p_gpio_out;
    !$past(rst) |-> (pin_oe & $past(gpio_sel)) == $past(gpio_sel & gpio_dir)
      && (pin_o & $past(gpio_sel & gpio_dir))
      == $past(gpio_sel & gpio_dir & gpio_out);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("pin out wrong");
  property p_gpio_in;
    !$past(rst) && !$past(rst, 2)
      |-> ((gpio_in ^ $past(pin_i, 2)) & gpio_sel) == 4'h0;
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("pin in wrong");
  property p_fifo;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_fifo: assert property (p_fifo) else $error("queue output moved");
endmodule
bind mbsp_top mbsp_top_sva u_sva (.*);

// File: dv/multibuffer_serial_port_bench.sv
`timescale 1ns/1ps
// ****************************************
// Bench for the serial port
// ****************************************
module multibuffer_serial_port_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic controller_mode = 1'b1;
  mbsp_pkg::mbsp_fmt_s fmt0 = '0;
  mbsp_pkg::mbsp_fmt_s fmt1 = '0;
  mbsp_pkg::mbsp_dly_s dly = '0;
  mbsp_pkg::mbsp_bufwr_s buf_wr = '0;
  mbsp_pkg::mbsp_bufrd_s buf_rd;
  logic [7:0] grp_first = 8'h00;
  logic [7:0] grp_last = 8'h00;
  logic [7:0] buf_rd_addr = 8'h00;
  logic grp_start = 1'b0;
  logic buf_wr_en = 1'b0;
  logic rx_ready = 1'b1;
  logic grp_busy, grp_done, rx_valid, miso;
  logic [15:0] rx_buffer, rx_data, got;
  logic [15:0] ptx = 16'h3C96;
  logic [3:0] plen = 4'h0;
  logic [3:0] gpio_sel = 4'h0;
  logic [3:0] gpio_out = 4'h0;
  logic [3:0] gpio_dir = 4'h0;
  logic [3:0] ext_q = 4'hF;
  logic [3:0] gpio_in, pin_i, pin_o, pin_oe;
  int per, lead, lag, rises;
  int pops = 0;
  int failures = 0;
  int checks_done = 0;
  // Word format rows, one word each
  localparam logic [3:0] LEN [4] = '{4'h1, 4'hF, 4'h7, 4'h4};
  localparam logic [7:0] PS [4] = '{8'h00, 8'h09, 8'h03, 8'h06};
  localparam logic POL [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic SEL [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] C2T [4] = '{8'h00, 8'h03, 8'h01, 8'h05};
  localparam logic [7:0] T2C [4] = '{8'h00, 8'h02, 8'h04, 8'h01};

  always #2.5 sys_clk = ~sys_clk;
  // Wire level from every driver of each pin
  assign pin_i = (pin_o & pin_oe) | ({ext_q[3], miso, ext_q[1:0]} & ~pin_oe);
  always @(posedge sys_clk) if (rx_valid && rx_ready) pops++;

  mbsp_top u_dut (.sys_clk, .rst, .controller_mode,
    .word_format_register_0 (fmt0), .word_format_register_1 (fmt1),
    .delay_setting_register (dly), .grp_first, .grp_last, .grp_start,
    .grp_busy, .grp_done, .buf_wr_en, .buf_wr, .buf_rd_addr, .buf_rd,
    .rx_buffer, .rx_valid, .rx_ready, .rx_data, .gpio_sel, .gpio_out,
    .gpio_dir, .gpio_in, .pin_i, .pin_o, .pin_oe);
  mbsp_partner u_peer (.sys_clk, .sclk (pin_i[0]), .sel_n (pin_i[3]),
    .mosi (pin_i[1]), .pol (fmt0.polarity), .tx_word (ptx), .tx_m1 (plen),
    .miso, .got, .per, .lead, .lag, .rises);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [15:0] c);
    @(posedge sys_clk);
    buf_wr_en <= 1'b1;
    buf_wr <= {a, d, c};
    @(posedge sys_clk);
    buf_wr_en <= 1'b0;
  endtask
  task automatic go(input logic [7:0] f, input logic [7:0] l);
    @(posedge sys_clk);
    grp_first <= f;
    grp_last <= l;
    grp_start <= 1'b1;
    @(posedge sys_clk);
    grp_start <= 1'b0;
  endtask
  // Bounded wait, then let the pins settle
  task automatic fin;
    for (int i = 0; i < 4000 && grp_done !== 1'b1; i++) @(negedge sys_clk);
    chk({15'h0000, grp_done}, 16'h0001);
    repeat (4) @(negedge sys_clk);
  endtask
  // Period with the 40 MHz floor applied
  function automatic int perf(input logic [7:0] ps);
    int q;
    q = (ps == 8'h00) ? 2 : int'(ps) + 1;
    return (q < int'(mbsp_pkg::MIN_PER_CYC)) ? int'(mbsp_pkg::MIN_PER_CYC) : q;
  endfunction
  task automatic final_report;
    $display("Comparisons %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [15:0] m;
    int p;
    logic [7:0] cap;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({12'h000, pin_oe}, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      @(posedge sys_clk);
      fmt1 <= {PS[r], POL[r], LEN[r]};
      fmt0 <= SEL[r] ? {8'h14, POL[r], 4'hF} : {PS[r], POL[r], LEN[r]};
      dly <= {C2T[r], T2C[r]};
      plen <= LEN[r];
      wr(8'(r), 16'hA5C3, {15'h0000, SEL[r]});
      go(8'(r), 8'(r));
      fin;
      m = 16'hFFFF >> (4'hF - LEN[r]);
      p = perf(PS[r]);
      chk(got, 16'hA5C3 & m);
      chk(rx_buffer, 16'h3C96 & m);
      chk(16'(per), 16'(p));
      chk(16'(lead), 16'(C2T[r]) + 16'h0002);
      chk(16'(lag), 16'(p - p / 2 + T2C[r] + 1));
      @(posedge sys_clk);
      buf_rd_addr <= 8'(r);
      repeat (2) @(negedge sys_clk);
      chk(buf_rd.rx, 16'h3C96 & m);
      chk({15'h0000, buf_rd.status[0]}, 16'h0001);
    end
    // Top two entries, select released per word or held
    for (int h = 0; h < 2; h++) begin
      wr(8'hFE, 16'h1234, {14'h0000, h[0], 1'b0});
      wr(8'hFF, 16'h4321, 16'h0000);
      p = rises;
      go(8'hFE, 8'hFF);
      fin;
      chk(16'(rises - p), h ? 16'h0001 : 16'h0002);
      @(posedge sys_clk);
      buf_rd_addr <= 8'hFF;
      repeat (2) @(negedge sys_clk);
      chk({15'h0000, buf_rd.status[0]}, 16'h0001);
    end
    // Reader stalls: queue fills, group waits, then drains
    @(posedge sys_clk);
    fmt0 <= {8'h00, 1'b0, 4'h1};
    rx_ready <= 1'b0;
    for (int i = 0; i < 17; i++) wr(8'(i), 16'h0002, 16'h0000);
    pops = 0;
    go(8'h00, 8'h10);
    repeat (1000) @(negedge sys_clk);
    chk({15'h0000, grp_busy}, 16'h0001);
    @(posedge sys_clk);
    rx_ready <= 1'b1;
    fin;
    chk(16'(pops), 16'h0011);
    chk({15'h0000, rx_valid}, 16'h0000);
    // Spare pins as plain I/O
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      gpio_sel <= 4'hF;
      gpio_dir <= 4'h6;
      gpio_out <= k ? 4'h4 : 4'h2;
      ext_q <= k ? 4'h1 : 4'h8;
      repeat (4) @(negedge sys_clk);
      chk({12'h000, pin_oe}, 16'h0006);
      chk({12'h000, gpio_in}, k ? 16'h0005 : 16'h000A);
    end
    // Peripheral: the bench plays the controller on the pins
    @(posedge sys_clk);
    gpio_sel <= 4'h0;
    ext_q <= 4'h8;
    controller_mode <= 1'b0;
    fmt0 <= {8'h00, 1'b0, 4'h7};
    repeat (10) @(negedge sys_clk);
    chk({15'h0000, pin_oe[0]}, 16'h0000);
    wr(8'h20, 16'h00B4, 16'h0000);
    go(8'h20, 8'h20);
    ext_q <= 4'h0;
    m = 16'h005A;
    repeat (6) @(posedge sys_clk);
    // Data set with the leading edge, held past the trailing one
    for (int b = 7; b >= 0; b--) begin
      ext_q <= {2'b00, m[b], 1'b1};
      repeat (4) @(posedge sys_clk);
      cap[b] = pin_i[2];
      ext_q <= {2'b00, m[b], 1'b0};
      repeat (4) @(posedge sys_clk);
    end
    chk(rx_buffer, 16'h005A);
    chk({8'h00, cap}, 16'h00B4);
    chk({15'h0000, grp_busy}, 16'h0000);
    final_report;
  end
  // Hang guard, far beyond the expected run
  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    final_report;
  end
endmodule

// File: verilog/mbsp_pkg.sv
// ****************************************
// Shared constants and carriers
// ****************************************
package mbsp_pkg;

  // Data and memory sizes
  localparam int WORD_W      = 16;
  localparam int BUF_ENTRIES = 256;
  localparam int FIFO_DEPTH  = 16;
  localparam int LEN_MIN     = 2;

  // Clock rates, period count rounded up
  localparam int SYS_CLK_MHZ  = 200;
  localparam int SCLK_MAX_MHZ = 40;
  localparam logic [9:0] MIN_PER_CYC =
    10'((SYS_CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ);

  // Serial clock period with a zero prescale
  localparam logic [9:0] ZERO_PS_PER = 10'h002;

  // Chip select lead and lag adders
  localparam logic [9:0] LEAD_ADD      = 10'h002;
  localparam logic [9:0] LEAD_ADD_HOLD = 10'h003;
  localparam logic [9:0] LAG_ADD       = 10'h001;

  // Pin positions in the pin vectors
  localparam int PIN_N            = 4;
  localparam int SERIAL_CLOCK_PIN = 0;
  localparam int CTRL_OUT_PIN     = 1;
  localparam int CTRL_IN_PIN      = 2;
  localparam int SELECT_PIN       = 3;

  // Per-word control and status bits
  localparam int CTL_FMT_SEL  = 0;
  localparam int CTL_HOLD     = 1;
  localparam int STAT_DONE    = 0;
  localparam int STAT_OVERRUN = 1;

  // Values after reset
  localparam logic [3:0]  PIN_RST  = 4'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0]  PTR_RST  = 8'h00;
  localparam logic [9:0]  CNT_RST  = 10'h000;
  localparam logic [4:0]  BITS_RST = 5'h00;

  // Word format: length minus one, clock
  typedef struct packed {
    logic [7:0] prescale;
    logic       polarity;
    logic [3:0] len_m1;
  } mbsp_fmt_s;

  // Delay setting register
  typedef struct packed {
    logic [7:0] select_to_clock_delay;
    logic [7:0] clock_to_select_delay;
  } mbsp_dly_s;

  // Buffer write from the internal bus
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] tx;
    logic [15:0] ctrl;
  } mbsp_bufwr_s;

  // Buffer read answer
  typedef struct packed {
    logic [15:0] rx;
    logic [15:0] status;
  } mbsp_bufrd_s;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_LAG, ST_PERI
  } mbsp_state_e;

endpackage

// File: verilog/mbsp_top.sv
`timescale 1ns/1ps

// ****************************************
// Stream FIFO
// ****************************************
module mbsp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];      // Storage
  logic [AW:0]  wp_q, wp_d;   // Write pointer, wrap bit on top
  logic [AW:0]  rp_q, rp_d;   // Read pointer

  // Full when indices meet with wrap bits apart
  assign in_ready  = !((wp_q[AW] != rp_q[AW]) &&
                       (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem[rp_q[AW-1:0]];

  // Pointer advance
  always_comb begin
    wp_d = wp_q + (AW+1)'(in_valid && in_ready);
    rp_d = rp_q + (AW+1)'(out_valid && out_ready);
  end

  // Pointer registers and storage write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (in_valid && in_ready) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ****************************************
// Multi-buffered serial port
// ****************************************
module mbsp_top (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 controller_mode,
  input  wire mbsp_pkg::mbsp_fmt_s  word_format_register_0,
  input  wire mbsp_pkg::mbsp_fmt_s  word_format_register_1,
  input  wire mbsp_pkg::mbsp_dly_s  delay_setting_register,
  input  wire logic [7:0]           grp_first,
  input  wire logic [7:0]           grp_last,
  input  wire logic                 grp_start,
  output logic                      grp_busy,
  output logic                      grp_done,
  input  wire logic                 buf_wr_en,
  input  wire mbsp_pkg::mbsp_bufwr_s buf_wr,
  input  wire logic [7:0]           buf_rd_addr,
  output mbsp_pkg::mbsp_bufrd_s     buf_rd,
  output logic [15:0]               rx_buffer,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [15:0]               rx_data,
  input  wire logic [3:0]           gpio_sel,
  input  wire logic [3:0]           gpio_out,
  input  wire logic [3:0]           gpio_dir,
  output logic [3:0]                gpio_in,
  input  wire logic [3:0]           pin_i,
  output logic [3:0]                pin_o,
  output logic [3:0]                pin_oe
);

  logic [15:0] tx_ram   [mbsp_pkg::BUF_ENTRIES];
  logic [15:0] ctrl_ram [mbsp_pkg::BUF_ENTRIES];
  logic [15:0] rx_ram   [mbsp_pkg::BUF_ENTRIES];
  logic [15:0] stat_ram [mbsp_pkg::BUF_ENTRIES];

  mbsp_pkg::mbsp_state_e st_q, st_d;   // Sequencer
  mbsp_pkg::mbsp_fmt_s   fmt_q, fmt_d; // Format of word in flight
  logic [7:0]  ptr_q, ptr_d;    // Current entry
  logic [7:0]  last_q, last_d;  // Last entry of group
  logic        busy_q, busy_d;  // Group running
  logic        cs_q, cs_d;      // Select active
  logic        held_q, held_d;  // Select kept from last word
  logic        hold_q, hold_d;  // Hold flag of word in flight
  logic        sclk_q, sclk_d;  // Clock level, before polarity
  logic [15:0] sr_q, sr_d;      // Shift register
  logic [4:0]  bits_q, bits_d;  // Bits done
  logic [9:0]  cnt_q, cnt_d;    // Delay and half period count
  logic [15:0] rxb_q, rxb_d;    // Receive buffer register
  logic        done_q, done_d;  // Group done pulse
  logic        ldp_q, ldp_d;    // Peripheral reload pending
  logic [3:0]  s1_q, s2_q, s3_q; // Pin synchronisers and history
  logic [3:0]  fn_o, fn_oe;     // Serial function drive
  logic [3:0]  po_d, poe_d;     // Pin drive after the I/O mux
  logic [3:0]  po_q, poe_q;     // Registered pin drive
  mbsp_pkg::mbsp_bufrd_s rd_q;  // Buffer read data

  // Loader view of the current entry
  mbsp_pkg::mbsp_fmt_s ld_fmt;
  logic [15:0] ld_ctl, ld_sr;
  logic        word_done, fifo_rdy, ovr;
  logic [15:0] rx_word;
  logic [9:0]  per, hi, lo;
  logic        ck, ckp, cs_act, cs_prev, trail;

  // ****************************************
  // Helper functions
  // ****************************************

  function automatic logic [9:0] period(input logic [7:0] ps);
    logic [9:0] p;
    p = (ps == 8'h00) ? mbsp_pkg::ZERO_PS_PER
                      : {2'b00, ps} + 10'h001;
    // Slow floor keeps the link under its top rate
    if (p < mbsp_pkg::MIN_PER_CYC) begin
      p = mbsp_pkg::MIN_PER_CYC;
    end
    return p;
  endfunction

  // keep only the valid low bits
  function automatic logic [15:0] len_mask(input logic [3:0] lm1);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (4'(i) <= lm1);
    end
    return m;
  endfunction

  // ****************************************
  // Entry decode and clock timing
  // ****************************************

  always_comb begin
    ld_ctl = ctrl_ram[ptr_q];
    ld_fmt = ld_ctl[mbsp_pkg::CTL_FMT_SEL] ? word_format_register_1
                                           : word_format_register_0;
    ld_sr  = tx_ram[ptr_q] << (4'hF - ld_fmt.len_m1);
    per    = period(fmt_q.prescale);
    hi     = per >> 1;
    lo     = per - hi;
  end

  assign ck      = s2_q[mbsp_pkg::SERIAL_CLOCK_PIN] ^ fmt_q.polarity;
  assign ckp     = s3_q[mbsp_pkg::SERIAL_CLOCK_PIN] ^ fmt_q.polarity;
  assign trail   = ckp && !ck;
  assign cs_act  = !s2_q[mbsp_pkg::SELECT_PIN];
  assign cs_prev = !s3_q[mbsp_pkg::SELECT_PIN];

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    st_d      = st_q;
    fmt_d     = fmt_q;
    ptr_d     = ptr_q;
    last_d    = last_q;
    busy_d    = busy_q;
    cs_d      = cs_q;
    held_d    = held_q;
    hold_d    = hold_q;
    sclk_d    = sclk_q;
    sr_d      = sr_q;
    bits_d    = bits_q;
    cnt_d     = cnt_q;
    done_d    = 1'b0;
    ldp_d     = 1'b0;
    word_done = 1'b0;
    case (st_q)
      mbsp_pkg::ST_IDLE: begin
        // group spans first to last entry
        if (grp_start && !busy_q) begin
          ptr_d  = grp_first;
          last_d = grp_last;
          busy_d = 1'b1;
          if (!controller_mode) begin
            st_d  = mbsp_pkg::ST_PERI;
            ldp_d = 1'b1;
          end
        end else if (busy_q && fifo_rdy) begin
          // Start only with room for the answer
          fmt_d  = ld_fmt;
          hold_d = ld_ctl[mbsp_pkg::CTL_HOLD];
          sr_d   = ld_sr;
          bits_d = mbsp_pkg::BITS_RST;
          cs_d   = 1'b1;
          cnt_d  = {2'b00, delay_setting_register.select_to_clock_delay}
                 + (held_q ? mbsp_pkg::LEAD_ADD_HOLD
                           : mbsp_pkg::LEAD_ADD) - 10'h001;
          st_d   = mbsp_pkg::ST_LEAD;
        end
      end
      mbsp_pkg::ST_LEAD: begin
        if (cnt_q == 10'h000) begin
          sclk_d = 1'b1;
          cnt_d  = hi - 10'h001;
          st_d   = mbsp_pkg::ST_HIGH;
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
      mbsp_pkg::ST_HIGH: begin
        if (cnt_q == 10'h000) begin
          sclk_d = 1'b0;
          sr_d   = {sr_q[14:0], s2_q[mbsp_pkg::CTRL_IN_PIN]};
          bits_d = bits_q + 5'h01;
          if (bits_q[3:0] == fmt_q.len_m1) begin
            cnt_d = lo + {2'b00,
                    delay_setting_register.clock_to_select_delay}
                  + mbsp_pkg::LAG_ADD - 10'h001;
            st_d  = mbsp_pkg::ST_LAG;
          end else begin
            cnt_d = lo - 10'h001;
            st_d  = mbsp_pkg::ST_LOW;
          end
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
      mbsp_pkg::ST_LOW: begin
        // next leading edge after low half
        if (cnt_q == 10'h000) begin
          sclk_d = 1'b1;
          cnt_d  = hi - 10'h001;
          st_d   = mbsp_pkg::ST_HIGH;
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
      mbsp_pkg::ST_LAG: begin
        if (cnt_q == 10'h000) begin
          word_done = 1'b1;
          st_d      = mbsp_pkg::ST_IDLE;
          if (ptr_q == last_q) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            cs_d   = 1'b0;
            held_d = 1'b0;
          end else begin
            ptr_d  = ptr_q + 8'h01;
            held_d = hold_q;
            cs_d   = hold_q;
          end
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
      mbsp_pkg::ST_PERI: begin
        // load on select or after each word
        if (ldp_q || (cs_act && !cs_prev)) begin
          fmt_d  = ld_fmt;
          sr_d   = ld_sr;
          bits_d = mbsp_pkg::BITS_RST;
        end else if (cs_act && trail) begin
          // take controller data on trailing edge
          sr_d   = {sr_q[14:0], s2_q[mbsp_pkg::CTRL_OUT_PIN]};
          bits_d = bits_q + 5'h01;
          if (bits_q[3:0] == fmt_q.len_m1) begin
            word_done = 1'b1;
            if (ptr_q == last_q) begin
              busy_d = 1'b0;
              done_d = 1'b1;
              st_d   = mbsp_pkg::ST_IDLE;
            end else begin
              ptr_d = ptr_q + 8'h01;
              ldp_d = 1'b1;
            end
          end
        end
      end
      default: begin
        st_d = mbsp_pkg::ST_IDLE;
      end
    endcase
  end

  // finished word lands in receive register
  assign rx_word = sr_d & len_mask(fmt_q.len_m1);
  assign rxb_d   = word_done ? rx_word : rxb_q;
  // Peripheral cannot stall its master, so mark loss
  assign ovr     = word_done && !fifo_rdy;

  // ****************************************
  // Pin drive and general I/O
  // ****************************************

  // drive set by mode and polarity
  always_comb begin
    fn_o  = 4'h0;
    fn_oe = 4'h0;
    if (controller_mode) begin
      fn_o[mbsp_pkg::SERIAL_CLOCK_PIN]  = sclk_q ^ fmt_q.polarity;
      fn_o[mbsp_pkg::CTRL_OUT_PIN]      = sr_q[15];
      fn_o[mbsp_pkg::SELECT_PIN]        = !cs_q;
      fn_oe[mbsp_pkg::SERIAL_CLOCK_PIN] = 1'b1;
      fn_oe[mbsp_pkg::CTRL_OUT_PIN]     = 1'b1;
      fn_oe[mbsp_pkg::SELECT_PIN]       = 1'b1;
    end else begin
      fn_o[mbsp_pkg::CTRL_IN_PIN]  = sr_q[15];
      fn_oe[mbsp_pkg::CTRL_IN_PIN] = (st_q == mbsp_pkg::ST_PERI) && cs_act;
    end
  end

  for (genvar g = 0; g < mbsp_pkg::PIN_N; g++) begin : g_pin
    assign po_d[g]  = gpio_sel[g] ? gpio_out[g] : fn_o[g];
    assign poe_d[g] = gpio_sel[g] ? gpio_dir[g] : fn_oe[g];
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q   <= mbsp_pkg::ST_IDLE;
      fmt_q  <= '0;
      ptr_q  <= mbsp_pkg::PTR_RST;
      last_q <= mbsp_pkg::PTR_RST;
      busy_q <= 1'b0;
      cs_q   <= 1'b0;
      held_q <= 1'b0;
      hold_q <= 1'b0;
      sclk_q <= 1'b0;
      sr_q   <= mbsp_pkg::WORD_RST;
      bits_q <= mbsp_pkg::BITS_RST;
      cnt_q  <= mbsp_pkg::CNT_RST;
      rxb_q  <= mbsp_pkg::WORD_RST;
      done_q <= 1'b0;
      ldp_q  <= 1'b0;
      s1_q   <= mbsp_pkg::PIN_RST;
      s2_q   <= mbsp_pkg::PIN_RST;
      s3_q   <= mbsp_pkg::PIN_RST;
      po_q   <= mbsp_pkg::PIN_RST;
      poe_q  <= mbsp_pkg::PIN_RST;
      rd_q   <= '0;
    end else begin
      st_q   <= st_d;
      fmt_q  <= fmt_d;
      ptr_q  <= ptr_d;
      last_q <= last_d;
      busy_q <= busy_d;
      cs_q   <= cs_d;
      held_q <= held_d;
      hold_q <= hold_d;
      sclk_q <= sclk_d;
      sr_q   <= sr_d;
      bits_q <= bits_d;
      cnt_q  <= cnt_d;
      rxb_q  <= rxb_d;
      done_q <= done_d;
      ldp_q  <= ldp_d;
      s1_q   <= pin_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      po_q   <= po_d;
      poe_q  <= poe_d;
      rd_q   <= {rx_ram[buf_rd_addr], stat_ram[buf_rd_addr]};
    end
  end

  // bus writes tx and control, engine rx and status
  always_ff @(posedge sys_clk) begin
    if (buf_wr_en) begin
      tx_ram[buf_wr.addr]   <= buf_wr.tx;
      ctrl_ram[buf_wr.addr] <= buf_wr.ctrl;
    end
    if (word_done) begin
      rx_ram[ptr_q]   <= rx_word;
      stat_ram[ptr_q] <= (16'h0001 << mbsp_pkg::STAT_DONE)
                       | (16'(ovr) << mbsp_pkg::STAT_OVERRUN);
    end
  end

  // ****************************************
  // Receive stream buffer
  // ****************************************
  mbsp_fifo #(
    .W (mbsp_pkg::WORD_W),
    .D (mbsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (word_done),
    .in_ready  (fifo_rdy),
    .in_data   (rx_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign grp_busy  = busy_q;
  assign grp_done  = done_q;
  assign rx_buffer = rxb_q;
  assign buf_rd    = rd_q;
  assign gpio_in   = s2_q;
  assign pin_o     = po_q;
  assign pin_oe    = poe_q;

endmodule
